// file: hdl/hsd_pkg.sv
// constants for the headset detect reporting and mask block
// assumes a 100 MHz system clock and an abstract byte-wide register port
package hsd_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TRIG_DELAY_MS = 120;
    localparam int unsigned TRIG_DELAY_CYC = TRIG_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned MEAS_STEP_CYC = 16;
    localparam logic [7:0] ADDR_STATUS = 8'h06;
    localparam logic [7:0] ADDR_MASK = 8'h07;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam int unsigned BIT_TRISTATE = 4;
    localparam int unsigned BIT_ERR = 3;
    localparam int unsigned BIT_IRQMODE = 2;
    localparam int unsigned BIT_MIC = 1;
    localparam int unsigned BIT_3P = 0;
    localparam logic [7:0] MASK_WMASK = 8'h1b;
    localparam logic [7:0] CTRL_WMASK = 8'h0c;
    localparam logic [6:0] I2C_ADDR_LO = 7'h3b;
    localparam logic [6:0] I2C_ADDR_HI = 7'h3c;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_MEAS_A = 3'b011,
        ST_MEAS_B = 3'b010,
        ST_DONE = 3'b110
    } hsd_state_type;
endpackage

// file: hdl/hsd_top.sv
// headset detect sequencer, flag reporting and interrupt mask register
// assumes an external byte register port already decoded from the serial bus
`timescale 1ns/1ns
module hsd_top #(
    parameter int unsigned TRIG_DELAY = hsd_pkg::TRIG_DELAY_CYC // 120 ms delay cycles
) (
    input wire logic clk_in, // 100 MHz clock
    input wire logic nrst_in, // async reset, active low
    input wire logic detect_start_pin_in, // start level from jack switch
    input wire logic slave_addr_select_in, // address strap level
    input wire logic ring2_low_z_in, // ring2 measured low impedance
    input wire logic sleeve_low_z_in, // sleeve measured low impedance
    input wire logic reg_wr_in, // register write strobe
    input wire logic reg_rd_in, // register read strobe
    input wire logic [7:0] reg_addr_in, // register address
    input wire logic [7:0] reg_wdata_in, // register write data
    output logic [7:0] reg_rdata_out, // register read data
    output logic [6:0] slave_addr_out, // active slave address
    output logic mic_on_sleeve_out, // mic line routed to sleeve
    output logic mic_on_ring2_out, // mic line routed to ring2
    output logic gnd_on_sleeve_out, // ground routed to sleeve
    output logic gnd_on_ring2_out, // ground routed to ring2
    output logic mic_found_n_pin_out, // open drain output level, always 0
    output logic mic_found_n_pin_oe_out // high while pulling pin low
);
    typedef struct packed {
        logic trig_prev;
        logic [31:0] cnt;
        hsd_pkg::hsd_state_type state;
        logic [7:0] mask;
        logic [7:0] ctrl;
        logic [7:0] status;
        logic [7:0] rdata;
        logic [3:0] route;
        logic oe;
    } hsd_regs_type;

    hsd_regs_type r_q, r_d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [2:0] irq_src;
    logic start_edge;

    // reset release through two flops; assertion is immediate
    // kept apart from the state struct since it runs on the raw reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    // edge only when the external start is enabled
    assign start_edge = detect_start_pin_in & ~r_q.trig_prev
        & ~r_q.ctrl[hsd_pkg::BIT_ERR];
    assign irq_src = {r_q.status[hsd_pkg::BIT_ERR] & ~r_q.mask[hsd_pkg::BIT_ERR],
        r_q.status[hsd_pkg::BIT_MIC] & ~r_q.mask[hsd_pkg::BIT_MIC],
        r_q.status[hsd_pkg::BIT_3P] & ~r_q.mask[hsd_pkg::BIT_3P]};

    // next state: sequencer, registers, pin
    always_comb begin
        r_d = r_q;
        r_d.trig_prev = detect_start_pin_in;
        if (r_q.cnt != 32'h0000_0000) begin
            r_d.cnt = r_q.cnt - 32'h0000_0001;
        end
        case (r_q.state)
            hsd_pkg::ST_IDLE: begin
                if (start_edge) begin
                    r_d.state = hsd_pkg::ST_WAIT;
                    r_d.cnt = 32'(TRIG_DELAY - 1);
                end
            end
            hsd_pkg::ST_WAIT: begin
                if (r_q.cnt == 32'h0000_0000) begin
                    r_d.state = hsd_pkg::ST_MEAS_A;
                    r_d.cnt = 32'(hsd_pkg::MEAS_STEP_CYC - 1);
                end
            end
            hsd_pkg::ST_MEAS_A: begin
                if (r_q.cnt == 32'h0000_0000) begin
                    r_d.state = hsd_pkg::ST_MEAS_B;
                    r_d.cnt = 32'(hsd_pkg::MEAS_STEP_CYC - 1);
                end
            end
            hsd_pkg::ST_MEAS_B: begin
                if (r_q.cnt == 32'h0000_0000) begin
                    r_d.state = hsd_pkg::ST_DONE;
                    r_d.status = 8'h00;
                    // both low: three pole; one low: that contact is ground
                    if (ring2_low_z_in && sleeve_low_z_in) begin
                        r_d.status[hsd_pkg::BIT_3P] = 1'b1;
                        r_d.route = 4'b0011;
                    end else if (ring2_low_z_in != sleeve_low_z_in) begin
                        r_d.status[hsd_pkg::BIT_MIC] = 1'b1;
                        // mic on the high impedance contact, ground on the other
                        r_d.route = ring2_low_z_in ? 4'b1001 : 4'b0110;
                    end else begin
                        r_d.status[hsd_pkg::BIT_ERR] = 1'b1;
                        r_d.route = 4'b0000;
                    end
                end
            end
            hsd_pkg::ST_DONE: begin
                if (start_edge) begin
                    r_d.state = hsd_pkg::ST_WAIT;
                    r_d.cnt = 32'(TRIG_DELAY - 1);
                end
            end
            default: r_d.state = hsd_pkg::ST_IDLE;
        endcase
        // register port; reading status clears it unless a result lands now
        if (reg_wr_in && is_addr(reg_addr_in, hsd_pkg::ADDR_MASK)) begin
            r_d.mask = reg_wdata_in & hsd_pkg::MASK_WMASK;
        end
        if (reg_wr_in && is_addr(reg_addr_in, hsd_pkg::ADDR_CTRL)) begin
            r_d.ctrl = reg_wdata_in & hsd_pkg::CTRL_WMASK;
        end
        if (reg_rd_in) begin
            if (is_addr(reg_addr_in, hsd_pkg::ADDR_MASK)) begin
                r_d.rdata = r_q.mask;
            end else if (is_addr(reg_addr_in, hsd_pkg::ADDR_CTRL)) begin
                r_d.rdata = r_q.ctrl;
            end else if (is_addr(reg_addr_in, hsd_pkg::ADDR_STATUS)) begin
                r_d.rdata = r_q.status;
                if (!(r_q.state == hsd_pkg::ST_MEAS_B && r_q.cnt == 32'h0000_0000)) begin
                    r_d.status = 8'h00;
                end
            end else begin
                r_d.rdata = 8'h00;
            end
        end
        // pin: tristate mask wins, then irq mode, else mic presence
        if (r_q.mask[hsd_pkg::BIT_TRISTATE]) begin
            r_d.oe = 1'b0;
        end else if (r_q.ctrl[hsd_pkg::BIT_IRQMODE]) begin
            r_d.oe = |irq_src;
        end else begin
            // routed mic means mic found; status clears on read, so it cannot hold the pin
            r_d.oe = r_q.route[3] | r_q.route[2];
        end
    end

    // state register, everything but the reset synchroniser
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            r_q.trig_prev <= 1'b1; // a high level at reset is not an edge
            r_q.cnt <= 32'h0000_0000;
            r_q.state <= hsd_pkg::ST_IDLE;
            r_q.mask <= hsd_pkg::MASK_RST;
            r_q.ctrl <= hsd_pkg::CTRL_RST;
            r_q.status <= 8'h00;
            r_q.rdata <= 8'h00;
            r_q.route <= 4'b0000;
            r_q.oe <= 1'b0;
        end else begin
            r_q.trig_prev <= r_d.trig_prev;
            r_q.cnt <= r_d.cnt;
            r_q.state <= r_d.state;
            r_q.mask <= r_d.mask;
            r_q.ctrl <= r_d.ctrl;
            r_q.status <= r_d.status;
            r_q.rdata <= r_d.rdata;
            r_q.route <= r_d.route;
            r_q.oe <= r_d.oe;
        end
    end

    assign reg_rdata_out = r_q.rdata;
    assign slave_addr_out = slave_addr_select_in ? hsd_pkg::I2C_ADDR_HI
        : hsd_pkg::I2C_ADDR_LO;
    assign {mic_on_sleeve_out, mic_on_ring2_out, gnd_on_sleeve_out, gnd_on_ring2_out} = r_q.route;
    assign mic_found_n_pin_out = 1'b0;
    assign mic_found_n_pin_oe_out = r_q.oe;

    sequence s_mask_write;
        reg_wr_in && reg_addr_in == hsd_pkg::ADDR_MASK;
    endsequence
    AST_MASK_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n)
        s_mask_write |=> r_q.mask == ($past(reg_wdata_in) & hsd_pkg::MASK_WMASK))
        else $error("mask register did not take write");
    AST_TRISTATE: assert property (@(posedge clk_in) disable iff (!rst_n)
        $past(r_q.mask[hsd_pkg::BIT_TRISTATE]) |-> !mic_found_n_pin_oe_out)
        else $error("pin driven while tristated");
    AST_ERR_MASK: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.mask[hsd_pkg::BIT_ERR] |-> !irq_src[2])
        else $error("masked error raised irq");
    AST_MIC_MASK: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.mask[hsd_pkg::BIT_MIC] |-> !irq_src[1])
        else $error("masked mic raised irq");
    AST_3P_MASK: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.mask[hsd_pkg::BIT_3P] |-> !irq_src[0])
        else $error("masked three pole raised irq");
    AST_NO_LEVEL_START: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.state == hsd_pkg::ST_IDLE && !start_edge |=> r_q.state == hsd_pkg::ST_IDLE)
        else $error("detection started without edge");
    AST_DELAY: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.state == hsd_pkg::ST_IDLE && start_edge |=> r_q.cnt == 32'(TRIG_DELAY - 1))
        else $error("start delay not loaded");
    AST_DISABLE: assert property (@(posedge clk_in) disable iff (!rst_n)
        r_q.ctrl[hsd_pkg::BIT_ERR] && r_q.state == hsd_pkg::ST_IDLE
        |=> r_q.state == hsd_pkg::ST_IDLE)
        else $error("start taken while disabled");
    AST_ROUTE: assert property (@(posedge clk_in) disable iff (!rst_n)
        !(mic_on_sleeve_out && gnd_on_sleeve_out) && !(mic_on_ring2_out && gnd_on_ring2_out))
        else $error("mic and ground on one contact");
    AST_IRQ_PIN: assert property (@(posedge clk_in) disable iff (!rst_n)
        !r_q.mask[hsd_pkg::BIT_TRISTATE] && r_q.ctrl[hsd_pkg::BIT_IRQMODE] && (|irq_src)
        |=> mic_found_n_pin_oe_out)
        else $error("irq pin not pulled");
endmodule

// file: tb/hsd_jack_model.sv
// jack, plug and pull-up model standing on the far side of the detect block
// assumes kind 0 no contact, 1 three pole, 2 mic on sleeve, 3 mic on ring2
`timescale 1ns/1ns
module hsd_jack_model (
    input wire logic clk_in, // bench clock
    input wire logic inserted_in, // plug fully seated
    input wire logic [1:0] kind_in, // wiring of the plug
    input wire logic pin_oe_in, // device pulls the detect pin low
    input wire logic pin_drive_in, // level the device drives when enabled
    output logic detect_start_out, // jack switch level
    output logic ring2_low_z_out, // ring2 reads as ground
    output logic sleeve_low_z_out, // sleeve reads as ground
    output logic pin_level_out // resolved open drain level
);
    // switch closes a cycle after the contacts, so readings are stable first
    always_ff @(posedge clk_in) begin
        detect_start_out <= inserted_in;
    end
    // the two four pole wirings only swap ground and mic
    assign ring2_low_z_out = inserted_in && (kind_in == 2'd1 || kind_in == 2'd2);
    assign sleeve_low_z_out = inserted_in && (kind_in == 2'd1 || kind_in == 2'd3);
    // pull-up wins whenever the device lets go
    assign pin_level_out = pin_oe_in ? pin_drive_in : 1'b1;
endmodule

// file: tb/tb_top.sv
// self-checking bench for the detect, status and mask block
// assumes the byte register port stands in for the serial bus
`timescale 1ns/1ns
module tb_top;
    localparam int unsigned TDLY = 20;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic strap = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic ins = 1'b0;
    logic [1:0] kind = 2'd0;
    logic start, r2z, slz, pin_lvl, oe, pin_drv, ms, mr, gs, gr;
    logic [7:0] rdata;
    logic [6:0] saddr;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;
    // free running 100 MHz clock
    always #5 clk_in = ~clk_in;
    hsd_top #(.TRIG_DELAY(TDLY)) i_hsd_top (.clk_in(clk_in), .nrst_in(nrst_in),
        .detect_start_pin_in(start), .slave_addr_select_in(strap), .ring2_low_z_in(r2z),
        .sleeve_low_z_in(slz), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .slave_addr_out(saddr),
        .mic_on_sleeve_out(ms), .mic_on_ring2_out(mr), .gnd_on_sleeve_out(gs),
        .gnd_on_ring2_out(gr), .mic_found_n_pin_out(pin_drv), .mic_found_n_pin_oe_out(oe));
    hsd_jack_model i_hsd_jack_model (.clk_in(clk_in), .inserted_in(ins), .kind_in(kind),
        .pin_oe_in(oe), .pin_drive_in(pin_drv),
        .detect_start_out(start), .ring2_low_z_out(r2z),
        .sleeve_low_z_out(slz), .pin_level_out(pin_lvl));
    task automatic tally_and_finish();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one byte per access; strobe dropped on the edge that takes it
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic chk_rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        @(negedge clk_in);
        chk(name, rdata, exp);
    endtask
    task automatic pin_is(input logic exp);
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
        chk("pin", {7'h00, pin_lvl}, {7'h00, exp});
    endtask
    // pull the plug, reseat it, and look for no result after the delay but before the measurement ends
    task automatic plug_in(input logic [1:0] k);
        @(posedge clk_in);
        ins <= 1'b0;
        repeat (3) @(posedge clk_in);
        kind <= k;
        ins <= 1'b1;
        repeat (TDLY + 20) @(posedge clk_in);
        chk_rd("early", hsd_pkg::ADDR_STATUS, 8'h00);
        repeat (30) @(posedge clk_in);
    endtask
    // hang guard: well above the longest expected run
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        logic [7:0] st [4] = '{8'h08, 8'h01, 8'h02, 8'h02};
        logic [3:0] rt [4] = '{4'h0, 4'h0, 4'h9, 4'h6};
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        chk_rd("mask", hsd_pkg::ADDR_MASK, 8'h00);
        chk_rd("status", hsd_pkg::ADDR_STATUS, 8'h00);
        pin_is(1'b1);
        chk("addr", {1'b0, saddr}, {1'b0, hsd_pkg::I2C_ADDR_LO});
        @(posedge clk_in);
        strap <= 1'b1;
        @(negedge clk_in);
        chk("addr", {1'b0, saddr}, {1'b0, hsd_pkg::I2C_ADDR_HI});
        reg_wr(hsd_pkg::ADDR_MASK, 8'hff);
        chk_rd("mask", hsd_pkg::ADDR_MASK, 8'h1b);
        reg_wr(8'h20, 8'hff);
        chk_rd("unmapped", 8'h20, 8'h00);
        reg_wr(hsd_pkg::ADDR_MASK, 8'h00);
        // start disabled, then a static high level after enabling again
        reg_wr(hsd_pkg::ADDR_CTRL, 8'h08);
        plug_in(2'd2);
        chk_rd("status", hsd_pkg::ADDR_STATUS, 8'h00);
        reg_wr(hsd_pkg::ADDR_CTRL, 8'h00);
        repeat (70) @(posedge clk_in);
        chk_rd("status", hsd_pkg::ADDR_STATUS, 8'h00);
        // every plug class in presence mode
        for (int k = 0; k < 4; k++) begin
            plug_in(k[1:0]);
            pin_is(k < 2);
            if (k >= 2) begin
                chk("route", {4'h0, ms, mr, gs, gr}, {4'h0, rt[k]});
                reg_wr(hsd_pkg::ADDR_MASK, 8'h10);
                pin_is(1'b1);
                reg_wr(hsd_pkg::ADDR_MASK, 8'h00);
            end
            chk_rd("status", hsd_pkg::ADDR_STATUS, st[k]);
            pin_is(k < 2);
        end
        // interrupt mode: each flag, its mask bit, clear on read
        reg_wr(hsd_pkg::ADDR_CTRL, 8'h04);
        for (int k = 0; k < 4; k++) begin
            plug_in(k[1:0]);
            pin_is(1'b0);
            reg_wr(hsd_pkg::ADDR_MASK, st[k]);
            pin_is(1'b1);
            reg_wr(hsd_pkg::ADDR_MASK, 8'h00);
            pin_is(1'b0);
            chk_rd("status", hsd_pkg::ADDR_STATUS, st[k]);
            pin_is(1'b1);
        end
        tally_and_finish();
    end
endmodule
